//--- host_model.sv
// Host model driving the register port.
// Assumes writes are taken at an edge with regWrite high.
`timescale 1ns/100ps
module host_model(input wire clk, input wire [7:0] regRdata_q, output reg regWrite = 0,
  output reg [5:0] regAddr = 0, output reg [7:0] regWdata = 0);
  task wr(input [5:0] a, input [7:0] d);
  begin
    @(posedge clk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk) {regWrite, regWdata} <= {1'b0, ~d};
  end
  endtask
  task rd(input [5:0] a, output [7:0] d);
  begin
    @(posedge clk) regAddr <= a;
    @(posedge clk) #1 d = regRdata_q;
  end
  endtask
endmodule

//--- radio_state_control_config.v
// Configuration and decision logic of the main radio control state machine.
// Assumes register writes/reads by offset, and radio state events from the core state machine.
`timescale 1ns/100ps
`include "radio_state_control_defines.vh"
module radio_state_control_config
(
  input wire clk,
  input wire sys_rst,
  input wire clkEn,
  input wire regWrite,
  input wire [5:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata_q,
  input wire xoscStart,
  input wire rssiBelowThr,
  input wire rxPacketActive,
  input wire rxPacketDone,
  input wire txPacketDone,
  input wire leaveIdleToActive,
  input wire returnToIdle,
  input wire sleepState,
  output reg clearChannel_q,
  output reg [1:0] nextState_q,
  output reg nextStateValid_q,
  output reg calibrateReq_q,
  output reg chipReadyLow_q,
  output reg pinCtrlEnable_q,
  output reg xoscRun_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops
  reg rssiMeta_q;
  reg rssiSync_q;
  reg rxActMeta_q;
  reg rxActSync_q;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      rssiMeta_q <= 1'b0;
      rssiSync_q <= 1'b0;
      rxActMeta_q <= 1'b0;
      rxActSync_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rssiMeta_q <= rssiBelowThr;
      rssiSync_q <= rssiMeta_q;
      rxActMeta_q <= rxPacketActive;
      rxActSync_q <= rxActMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [5:0] exitPolicy_q;
  reg [5:0] calibPower_q;
  wire [1:0] clearChannelPolicy = exitPolicy_q[`CCA_HI:`CCA_LO];
  wire [1:0] afterReceiveNextState = exitPolicy_q[`RXOFF_HI:`RXOFF_LO];
  wire [1:0] afterTransmitNextState = exitPolicy_q[`TXOFF_HI:`TXOFF_LO];
  wire [1:0] synthAutocalPolicy = calibPower_q[`AUTOCAL_HI:`AUTOCAL_LO];
  wire [1:0] powerupWaitSelect = calibPower_q[`POWAIT_HI:`POWAIT_LO];

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      exitPolicy_q <= 6'h30;
      calibPower_q <= 6'h04;
      regRdata_q <= 8'h00;
    end
    else if (clkEn)
    begin
      if (regWrite && regAddr == `EXIT_POLICY_ADDR)
        exitPolicy_q <= regWdata[5:0];
      if (regWrite && regAddr == `CALIB_POWER_ADDR)
        calibPower_q <= regWdata[5:0];
      // Reserved bits read as zero
      case (regAddr)
        `EXIT_POLICY_ADDR: regRdata_q <= {2'h0, exitPolicy_q};
        `CALIB_POWER_ADDR: regRdata_q <= {2'h0, calibPower_q};
        default: regRdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear channel and next-state selection
  reg clearChannel_d;
  always @*
  begin
    case (clearChannelPolicy)
      2'h0: clearChannel_d = 1'b1;
      2'h1: clearChannel_d = rssiSync_q;
      2'h2: clearChannel_d = ~rxActSync_q;
      default: clearChannel_d = rssiSync_q & ~rxActSync_q;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      clearChannel_q <= 1'b1;
      nextState_q <= `NEXT_IDLE;
      nextStateValid_q <= 1'b0;
      pinCtrlEnable_q <= 1'b0;
      xoscRun_q <= 1'b1;
    end
    else if (clkEn)
    begin
      clearChannel_q <= clearChannel_d;
      nextStateValid_q <= rxPacketDone | txPacketDone;
      // Receive end wins if both finish together; encodings map directly
      if (rxPacketDone)
        nextState_q <= afterReceiveNextState;
      else if (txPacketDone)
        nextState_q <= afterTransmitNextState;
      pinCtrlEnable_q <= calibPower_q[`PINCTRL_BIT];
      xoscRun_q <= ~sleepState | calibPower_q[`XOSCON_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Autocalibration decision
  reg [1:0] idleReturnCount_q;
  reg calibrateReq_d;
  always @*
  begin
    case (synthAutocalPolicy)
      2'h0: calibrateReq_d = 1'b0;
      2'h1: calibrateReq_d = leaveIdleToActive;
      2'h2: calibrateReq_d = returnToIdle;
      default: calibrateReq_d = returnToIdle && idleReturnCount_q == 2'h3;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      idleReturnCount_q <= 2'h0;
      calibrateReq_q <= 1'b0;
    end
    else if (clkEn)
    begin
      calibrateReq_q <= calibrateReq_d;
      if (returnToIdle)
        idleReturnCount_q <= idleReturnCount_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up wait: ripple counter expirations before chip ready
  reg [`RIPPLE_BITS-1:0] ripple_q;
  reg [8:0] expireCount_q;
  reg waiting_q;
  reg [8:0] expireTarget;
  always @*
  begin
    case (powerupWaitSelect)
      2'h0: expireTarget = `WAIT_1;
      2'h1: expireTarget = `WAIT_16;
      2'h2: expireTarget = `WAIT_64;
      default: expireTarget = `WAIT_256;
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ripple_q <= 6'h00;
      expireCount_q <= 9'h000;
      waiting_q <= 1'b0;
      chipReadyLow_q <= 1'b1;
    end
    else if (clkEn)
    begin
      if (xoscStart)
      begin
        ripple_q <= 6'h00;
        expireCount_q <= 9'h000;
        waiting_q <= 1'b1;
        chipReadyLow_q <= 1'b1;
      end
      else if (waiting_q)
      begin
        ripple_q <= ripple_q + 6'h01;
        if (ripple_q == 6'h3F)
        begin
          expireCount_q <= expireCount_q + 9'h001;
          if (expireCount_q + 9'h001 == expireTarget)
          begin
            waiting_q <= 1'b0;
            chipReadyLow_q <= 1'b0;
          end
        end
      end
    end
  end

endmodule

//--- radio_state_control_config_tb.sv
// Self-checking bench of the radio control config block.
// Assumes the host model owns the register port.
`timescale 1ns/100ps
module radio_state_control_config_tb;
  reg clk = 0, sys_rst = 1, rssiBelowThr = 0, rxPacketActive = 0, sleepState = 1, cal;
  reg xoscStart = 0, rxPacketDone = 0, txPacketDone = 0, leaveIdleToActive = 0, returnToIdle = 0;
  wire clkEn = 1'b1;
  wire regWrite, clearChannel_q, nextStateValid_q, calibrateReq_q, chipReadyLow_q;
  wire pinCtrlEnable_q, xoscRun_q;
  wire [5:0] regAddr;
  wire [7:0] regWdata, regRdata_q;
  wire [1:0] nextState_q;
  reg [31:0] seed = 32'hB785;
  reg [7:0] d;
  integer bad_count = 0, checks = 0, i, n = 0, k;
  always #20 clk = ~clk;
  host_model i_host_model(.*);
  radio_state_control_config i_radio_state_control_config(.*);
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13) ^ ((s ^ (s << 13)) >> 17);
  endfunction
  function ccExp(input [1:0] m, input r, input a);
    ccExp = (m[0] ? r : 1'b1) & (m[1] ? !a : 1'b1);
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task pulse(input [4:0] p);
  begin
    @(posedge clk) {xoscStart, returnToIdle, leaveIdleToActive, txPacketDone, rxPacketDone} <= p;
    @(posedge clk) {xoscStart, returnToIdle, leaveIdleToActive, txPacketDone, rxPacketDone} <= 0;
    #1 cal = calibrateReq_q;
    repeat (2) @(posedge clk) #1 cal = cal | calibrateReq_q;
  end
  endtask
  task complete_run;
  begin
    $display("Checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    i_host_model.rd(6'h17, d);
    chk("exit reset", 8'h30, d);
    i_host_model.rd(6'h18, d);
    chk("calib reset", 8'h04, d);
    i_host_model.rd(6'h2A, d);
    chk("unmapped", 8'h00, d);
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = xs(seed);
      i_host_model.wr(6'h17, seed[15:8]);
      i_host_model.wr(6'h18, seed[7:0]);
      i_host_model.rd(6'h17, d);
      chk("exit rw", {2'b00, seed[13:8]}, d);
      i_host_model.rd(6'h18, d);
      chk("calib rw", {2'b00, seed[5:0]}, d);
      chk("pin ctrl", seed[1], pinCtrlEnable_q);
      chk("xosc run", seed[0], xoscRun_q);
    end
    @(posedge clk) sleepState <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("xosc awake", 1, xoscRun_q);
    for (i = 0; i < 16; i = i + 1)
    begin
      seed = xs(seed);
      @(posedge clk) {rssiBelowThr, rxPacketActive} <= seed[1:0];
      i_host_model.wr(6'h17, {2'b00, i[1:0], 4'h0});
      repeat (5) @(posedge clk);
      #1 chk("clear", ccExp(i[1:0], seed[1], seed[0]), clearChannel_q);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      i_host_model.wr(6'h17, {4'h0, i[1:0], ~i[1:0]});
      pulse(5'h01);
      chk("rx next", i[1:0], nextState_q);
      pulse(5'h02);
      chk("tx next", {14'h0000, ~i[1:0]}, nextState_q);
      pulse(5'h03);
      chk("both next", i[1:0], nextState_q);
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      if (i[1:0] == 0)
        i_host_model.wr(6'h18, {2'b00, i[3:2], 4'h0});
      pulse(5'h04);
      chk("cal leave", i[3:2] == 1, cal);
      pulse(5'h08);
      n = n + 1;
      chk("cal back", i[3:2] == 2 || (i[3:2] == 3 && n % 4 == 0), cal);
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      i_host_model.wr(6'h18, {4'h0, i[1:0], 2'b00});
      pulse(5'h10);
      chk("not ready", 1, chipReadyLow_q);
      for (k = 2; chipReadyLow_q !== 1'b0 && k < 2000; k = k + 1)
        @(posedge clk) #1;
      chk("ready wait", i ? 1024 : 64, k);
    end
    complete_run;
  end
endmodule

//--- radio_state_control_defines.vh
// Register offsets, field positions, reset values and encodings for the radio control config.
// Assumes a register port delivering 8-bit writes and reads addressed by offset.
`ifndef RADIO_STATE_CONTROL_DEFINES_VH
`define RADIO_STATE_CONTROL_DEFINES_VH
`define EXIT_POLICY_ADDR 6'h17
`define CALIB_POWER_ADDR 6'h18
`define EXIT_POLICY_RESET 8'h30
`define CALIB_POWER_RESET 8'h04
`define CCA_HI 5
`define CCA_LO 4
`define RXOFF_HI 3
`define RXOFF_LO 2
`define TXOFF_HI 1
`define TXOFF_LO 0
`define AUTOCAL_HI 5
`define AUTOCAL_LO 4
`define POWAIT_HI 3
`define POWAIT_LO 2
`define PINCTRL_BIT 1
`define XOSCON_BIT 0
`define RIPPLE_BITS 6
`define NEXT_IDLE 2'h0
`define NEXT_FSTXRDY 2'h1
`define NEXT_TX 2'h2
`define NEXT_RX 2'h3
`define WAIT_1 9'h001
`define WAIT_16 9'h010
`define WAIT_64 9'h040
`define WAIT_256 9'h100
`endif

//--- radio_state_control_sva.sv
// Port checker of the radio control config block.
// Assumes clkEn is held high by the bench.
`timescale 1ns/100ps
module radio_state_control_sva(input wire clk, sys_rst, regWrite, xoscStart, rssiBelowThr,
  rxPacketActive, rxPacketDone, txPacketDone, leaveIdleToActive, returnToIdle,
  nextStateValid_q, calibrateReq_q, chipReadyLow_q, pinCtrlEnable_q, clearChannel_q,
  input wire [5:0] regAddr, input wire [7:0] regRdata_q, input wire [1:0] nextState_q);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_quiet; (rssiBelowThr && !rxPacketActive)[*4]; endsequence
  sequence s_idle; !rxPacketDone && !txPacketDone; endsequence
  property p_rx; rxPacketDone |=> nextStateValid_q; endproperty
  a_rx: assert property (p_rx) else $error("no valid after rx");
  property p_tx; txPacketDone |=> nextStateValid_q; endproperty
  a_tx: assert property (p_tx) else $error("no valid after tx");
  property p_nv; s_idle |=> !nextStateValid_q; endproperty
  a_nv: assert property (p_nv) else $error("stray valid");
  property p_ns; s_idle |=> $stable(nextState_q); endproperty
  a_ns: assert property (p_ns) else $error("next state moved");
  property p_cal; !leaveIdleToActive && !returnToIdle |=> !calibrateReq_q; endproperty
  a_cal: assert property (p_cal) else $error("stray calibrate");
  property p_cc; s_quiet |-> clearChannel_q; endproperty
  a_cc: assert property (p_cc) else $error("channel not clear");
  property p_cr; xoscStart |=> chipReadyLow_q[*8]; endproperty
  a_cr: assert property (p_cr) else $error("ready too early");
  property p_pin; !regWrite ##1 !regWrite |=> $stable(pinCtrlEnable_q); endproperty
  a_pin: assert property (p_pin) else $error("pin control moved");
endmodule
bind radio_state_control_config radio_state_control_sva i_radio_state_control_sva(.*);
